// ---- verilog/lsp_pkg.sv ----
`default_nettype none
// shared constants and carriers of the line supervision parameter bank
package lsp_pkg;

  // apb geometry: byte address is four times the register index
  localparam int unsigned APB_AW  = 12;
  localparam int unsigned APB_DW  = 32;
  localparam int unsigned IDX_W   = 8;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned STRB_W  = APB_DW / 8;

  // register indices as printed
  localparam logic [IDX_W-1:0] IDX_LC_UPPER   = 8'h1c;
  localparam logic [IDX_W-1:0] IDX_RT_THR     = 8'h1d;
  localparam logic [IDX_W-1:0] IDX_CM_LOW     = 8'h1e;
  localparam logic [IDX_W-1:0] IDX_CM_HIGH    = 8'h1f;
  localparam logic [IDX_W-1:0] IDX_PA_ONE     = 8'h20;
  localparam logic [IDX_W-1:0] IDX_PA_TWO     = 8'h21;
  localparam logic [IDX_W-1:0] IDX_PA_THREE   = 8'h22;
  localparam logic [IDX_W-1:0] IDX_LC_COEFF   = 8'h23;
  localparam logic [IDX_W-1:0] IDX_RT_COEFF   = 8'h24;
  localparam logic [IDX_W-1:0] IDX_TP_ONE     = 8'h25;
  localparam logic [IDX_W-1:0] IDX_TP_TWO     = 8'h26;
  localparam logic [IDX_W-1:0] IDX_TP_THREE   = 8'h27;
  localparam logic [IDX_W-1:0] IDX_RING_BIAS  = 8'h28;
  localparam logic [IDX_W-1:0] IDX_OVERHEAD   = 8'h29;
  localparam logic [IDX_W-1:0] IDX_RESERVED   = 8'h2a;
  localparam logic [IDX_W-1:0] IDX_LC_LOWER   = 8'h2b;
  // control and status of the block itself
  localparam logic [IDX_W-1:0] IDX_CTRL       = 8'h30;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 8'h31;

  // parameter storage
  localparam int unsigned      NUM_PARAM   = 16;
  localparam int unsigned      PARAM_W     = 16;
  localparam int unsigned      SLOT_W      = 4;
  localparam logic [PARAM_W-1:0] PARAM_RST = 16'h0000;
  localparam logic [IDX_W-1:0] PARAM_BASE  = IDX_LC_UPPER;
  localparam logic [IDX_W-1:0] PARAM_LAST  = IDX_LC_LOWER;

  localparam logic [SLOT_W-1:0] SLOT_LC_UPPER  = SLOT_W'(IDX_LC_UPPER - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_RT_THR    = SLOT_W'(IDX_RT_THR - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_CM_LOW    = SLOT_W'(IDX_CM_LOW - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_CM_HIGH   = SLOT_W'(IDX_CM_HIGH - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_PA_ONE    = SLOT_W'(IDX_PA_ONE - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_LC_COEFF  = SLOT_W'(IDX_LC_COEFF - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_RT_COEFF  = SLOT_W'(IDX_RT_COEFF - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_TP_ONE    = SLOT_W'(IDX_TP_ONE - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_RING_BIAS = SLOT_W'(IDX_RING_BIAS - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_OVERHEAD  = SLOT_W'(IDX_OVERHEAD - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_RESERVED  = SLOT_W'(IDX_RESERVED - PARAM_BASE);
  localparam logic [SLOT_W-1:0] SLOT_LC_LOWER  = SLOT_W'(IDX_LC_LOWER - PARAM_BASE);

  // field widths; every field sits from bit 0 upward
  localparam int unsigned LC_W      = 6;   // 1.27 mA per step, 0 to 80 mA
  localparam int unsigned RT_W      = 6;
  localparam int unsigned CM_W      = 6;   // 0.375 V per step, 0 to 23.625 V
  localparam int unsigned PA_W      = 8;
  localparam int unsigned COEF_W    = 13;
  localparam int unsigned BIAS_W    = 4;
  localparam int unsigned OVH_W     = 4;
  localparam int unsigned NUM_PAIRS = 3;
  localparam int unsigned CMP_W     = 8;   // common width of all threshold compares

  // control register bits
  localparam int unsigned CTRL_W        = 2;
  localparam int unsigned CTRL_HYST_BIT = 0;
  localparam int unsigned CTRL_OVR_BIT  = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

  // status register bits
  localparam int unsigned STAT_LOOP_BIT  = 0;
  localparam int unsigned STAT_RTRIP_BIT = 1;
  localparam int unsigned STAT_SPEED_BIT = 2;
  localparam int unsigned STAT_PA_LSB    = 3;

  typedef struct packed {
    logic [LC_W-1:0]                 loop_current;
    logic [CM_W-1:0]                 cm_low;
    logic [CM_W-1:0]                 cm_high;
    logic [NUM_PAIRS-1:0][PA_W-1:0]  pair_power;
  } lsp_meas_t;

  typedef struct packed {
    logic                            loop_closed;
    logic                            ring_trip;
    logic                            speedup;
    logic [NUM_PAIRS-1:0]            power_alarm;
  } lsp_det_t;

  typedef struct packed {
    logic [COEF_W-1:0]               lc_coeff;
    logic [COEF_W-1:0]               rt_coeff;
    logic [NUM_PAIRS-1:0][COEF_W-1:0] thermal_pole;
    logic [BIAS_W-1:0]               ring_bias;
    logic [OVH_W-1:0]                overhead;
    logic                            overhead_range_select;
  } lsp_cfg_t;

  // values are unsigned; each field is widened with a zero sign bit, so the signed compare orders them as unsigned
  function automatic logic lsp_code_above(input logic [CMP_W-1:0] level,
                                          input logic [CMP_W-1:0] thr);
    lsp_code_above = $signed({1'b0, level}) > $signed({1'b0, thr});
  endfunction

  // merge the low two byte lanes of a write into a 16-bit word
  function automatic logic [PARAM_W-1:0] lsp_merge(input logic [PARAM_W-1:0] old,
                                                   input logic [APB_DW-1:0]  wdata,
                                                   input logic [STRB_W-1:0]  strb);
    lsp_merge = old;
    if (strb[0]) lsp_merge[7:0] = wdata[7:0];
    if (strb[1]) lsp_merge[15:8] = wdata[15:8];
  endfunction

endpackage
`default_nettype wire

// ---- verilog/lsp_hyst_cmp.sv ----
`default_nettype none
// threshold detector with optional hysteresis band
module lsp_hyst_cmp
  import lsp_pkg::*;
#(
  parameter int unsigned W = LC_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] level_i,
  input  wire logic [W-1:0] upper_i,
  input  wire logic [W-1:0] lower_i,
  input  wire logic         hyst_en_i,
  output var  logic         state_o
);
  logic state_q;
  logic state_d;
  logic above_upper;
  logic below_lower;

  assign above_upper = lsp_code_above(CMP_W'(level_i), CMP_W'(upper_i));
  assign below_lower = lsp_code_above(CMP_W'(lower_i), CMP_W'(level_i));

  // with hysteresis on, closed state holds inside the band, only leaving below the lower bound
  always_comb begin
    if (!hyst_en_i) begin
      state_d = above_upper;
    end else if (state_q) begin
      state_d = !below_lower;
    end else begin
      state_d = above_upper;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_hyst_hold_band: assert property (
    hyst_en_i && state_q && !below_lower |=> state_q)
    else $error("closed state dropped inside hysteresis band");

  chk_hyst_release: assert property (
    hyst_en_i && state_q && below_lower |=> !state_q)
    else $error("closed state not released below lower bound");

  chk_single_thresh: assert property (
    !hyst_en_i |=> state_q == $past(above_upper))
    else $error("single threshold compare wrong without hysteresis");

endmodule
`default_nettype wire

// ---- verilog/lsp_param_bank.sv ----
`default_nettype none
module lsp_param_bank
  import lsp_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [lsp_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [lsp_pkg::APB_DW-1:0] pwdata_i,
  input  wire logic [lsp_pkg::STRB_W-1:0] pstrb_i,
  output var  logic [lsp_pkg::APB_DW-1:0] prdata_o,
  output var  logic                    pready_o,
  output var  logic                    pslverr_o,
  input  wire logic                    ringing_active_i,
  input  wire lsp_pkg::lsp_meas_t      meas_i,
  output var  lsp_pkg::lsp_det_t       det_o,
  output var  lsp_pkg::lsp_cfg_t       cfg_o
);
  import lsp_pkg::*;

  // ---- input synchronisers
  lsp_meas_t meas_s1_q;
  lsp_meas_t meas_s1_d;
  lsp_meas_t meas_s2_q;
  lsp_meas_t meas_s2_d;
  logic      ring_s1_q;
  logic      ring_s1_d;
  logic      ring_s2_q;
  logic      ring_s2_d;

  // analog codes arrive asynchronously; a word may tear for one sample,
  // which reaches the detector compares unfiltered
  always_comb begin
    meas_s1_d = meas_i;
    meas_s2_d = meas_s1_q;
    ring_s1_d = ringing_active_i;
    ring_s2_d = ring_s1_q;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meas_s1_q <= '0;
      meas_s2_q <= '0;
      ring_s1_q <= 1'b0;
      ring_s2_q <= 1'b0;
    end else begin
      meas_s1_q <= meas_s1_d;
      meas_s2_q <= meas_s2_d;
      ring_s1_q <= ring_s1_d;
      ring_s2_q <= ring_s2_d;
    end
  end

  // ---- apb decode
  logic [IDX_W-1:0]  idx;
  logic [SLOT_W-1:0] slot;
  logic              hit_param;
  logic              hit_ctrl;
  logic              hit_status;
  logic              mapped;
  logic              setup;
  logic              wr_done;

  assign idx        = paddr_i[IDX_LSB +: IDX_W];
  assign slot       = SLOT_W'(idx - PARAM_BASE);
  assign hit_param  = (idx >= PARAM_BASE) && (idx <= PARAM_LAST);
  assign hit_ctrl   = (idx == IDX_CTRL);
  assign hit_status = (idx == IDX_STATUS);
  assign mapped     = hit_param || hit_ctrl || hit_status;
  assign setup      = psel_i && !penable_i;

  // ---- register file and bus answer
  logic [PARAM_W-1:0] param_q [NUM_PARAM];
  logic [PARAM_W-1:0] param_d [NUM_PARAM];
  logic [CTRL_W-1:0]  ctrl_q;
  logic [CTRL_W-1:0]  ctrl_d;
  logic [APB_DW-1:0]  prdata_q;
  logic [APB_DW-1:0]  prdata_d;
  logic               pready_q;
  logic               pready_d;
  logic               pslverr_q;
  logic               pslverr_d;
  logic [PARAM_W-1:0] status_word;
  logic [PARAM_W-1:0] ctrl_word;
  logic [PARAM_W-1:0] rd_word;
  lsp_det_t           det_now;

  // a write lands only at the edge where the master sees pready high
  assign wr_done     = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;

  assign status_word = PARAM_W'({det_now.power_alarm, det_now.speedup,
                                 det_now.ring_trip, det_now.loop_closed});
  assign ctrl_word   = PARAM_W'(ctrl_q);

  // read mux; the reserved slot and unmapped words read as zero
  always_comb begin
    rd_word = '0;
    if (hit_param && slot != SLOT_RESERVED) begin
      rd_word = param_q[slot];
    end else if (hit_ctrl) begin
      rd_word = ctrl_word;
    end else if (hit_status) begin
      rd_word = status_word;
    end
  end

  // answer is registered: pready rises in the first access cycle, so every
  // transfer takes exactly two cycles and back-to-back transfers still work
  always_comb begin
    param_d   = param_q;
    ctrl_d    = ctrl_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = '0;
    if (setup) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      if (!pwrite_i) begin
        prdata_d = APB_DW'(rd_word);
      end
    end
    if (wr_done) begin
      if (hit_param && slot != SLOT_RESERVED) begin
        // all 16 bits are kept, unused ones included
        param_d[slot] = lsp_merge(param_q[slot], pwdata_i, pstrb_i);
      end else if (hit_ctrl) begin
        ctrl_d = CTRL_W'(lsp_merge(ctrl_word, pwdata_i, pstrb_i));
      end
    end
  end

  // parameters clear to zero only to keep simulation free of unknowns;
  // software must still program each one before use
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_PARAM; i++) begin
        param_q[i] <= PARAM_RST;
      end
      ctrl_q    <= CTRL_RST;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_PARAM; i++) begin
        param_q[i] <= param_d[i];
      end
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  // field views; only the defined low bits steer detection
  logic [LC_W-1:0] lc_upper;
  logic [LC_W-1:0] lc_lower;
  logic [RT_W-1:0] rt_thr;
  logic [CM_W-1:0] cml_thr;
  logic [CM_W-1:0] cmh_thr;

  assign lc_upper = param_q[SLOT_LC_UPPER][LC_W-1:0];
  assign lc_lower = param_q[SLOT_LC_LOWER][LC_W-1:0];
  assign rt_thr   = param_q[SLOT_RT_THR][RT_W-1:0];
  assign cml_thr  = param_q[SLOT_CM_LOW][CM_W-1:0];
  assign cmh_thr  = param_q[SLOT_CM_HIGH][CM_W-1:0];

  // ---- loop closure with optional hysteresis
  logic loop_closed;

  lsp_hyst_cmp #(
    .W (LC_W)
  ) u_loop_cmp (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .level_i   (meas_s2_q.loop_current),
    .upper_i   (lc_upper),
    .lower_i   (lc_lower),
    .hyst_en_i (ctrl_q[CTRL_HYST_BIT]),
    .state_o   (loop_closed)
  );

  // ---- ring trip, speed-up and power alarms
  logic                 rtrip_q;
  logic                 rtrip_d;
  logic                 speed_q;
  logic                 speed_d;
  logic [NUM_PAIRS-1:0] palarm_q;
  logic [NUM_PAIRS-1:0] palarm_d;

  // ring trip is meaningless off-hook without ringing, so it is gated
  always_comb begin
    rtrip_d = ring_s2_q &&
              lsp_code_above(CMP_W'(meas_s2_q.loop_current), CMP_W'(rt_thr));
    speed_d = lsp_code_above(CMP_W'(meas_s2_q.cm_low), CMP_W'(cml_thr))
           || lsp_code_above(CMP_W'(meas_s2_q.cm_high), CMP_W'(cmh_thr));
    for (int p = 0; p < NUM_PAIRS; p++) begin
      palarm_d[p] = lsp_code_above(meas_s2_q.pair_power[p],
                                   param_q[SLOT_PA_ONE + SLOT_W'(p)][PA_W-1:0]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rtrip_q  <= 1'b0;
      speed_q  <= 1'b0;
      palarm_q <= '0;
    end else begin
      rtrip_q  <= rtrip_d;
      speed_q  <= speed_d;
      palarm_q <= palarm_d;
    end
  end

  assign det_now.loop_closed = loop_closed;
  assign det_now.ring_trip   = rtrip_q;
  assign det_now.speedup     = speed_q;
  assign det_now.power_alarm = palarm_q;
  assign det_o               = det_now;

  // ---- configuration handed to the analog filters and converter
  always_comb begin
    cfg_o.lc_coeff = param_q[SLOT_LC_COEFF][COEF_W-1:0];
    cfg_o.rt_coeff = param_q[SLOT_RT_COEFF][COEF_W-1:0];
    for (int p = 0; p < NUM_PAIRS; p++) begin
      cfg_o.thermal_pole[p] = param_q[SLOT_TP_ONE + SLOT_W'(p)][COEF_W-1:0];
    end
    cfg_o.ring_bias             = param_q[SLOT_RING_BIAS][BIAS_W-1:0];
    // the range limit of the overhead field is software's to respect
    cfg_o.overhead              = param_q[SLOT_OVERHEAD][OVH_W-1:0];
    cfg_o.overhead_range_select = ctrl_q[CTRL_OVR_BIT];
  end

  // ---- checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_apb_ready_timing: assert property (
    setup |=> pready_q ##1 !pready_q || (psel_i && !penable_i))
    else $error("apb answer not given in the first access cycle");

  chk_param_write_store: assert property (
    wr_done && hit_param && slot != SLOT_RESERVED && pstrb_i[1:0] == 2'h3
    |=> param_q[$past(slot)] == $past(pwdata_i[PARAM_W-1:0]))
    else $error("full 16-bit parameter word not stored");

  chk_read_back_word: assert property (
    setup && !pwrite_i && hit_param && slot != SLOT_RESERVED
    |=> prdata_q == APB_DW'(param_q[$past(slot)]))
    else $error("parameter read does not return the stored word");

  chk_unmapped_error: assert property (
    setup && !mapped |=> pslverr_q && prdata_q == '0)
    else $error("unmapped address not refused");

  chk_ring_trip_gate: assert property (
    !ring_s2_q |=> !rtrip_q)
    else $error("ring trip seen while not ringing");

  chk_speedup_low: assert property (
    lsp_code_above(CMP_W'(meas_s2_q.cm_low), CMP_W'(cml_thr)) |=> speed_q)
    else $error("negative common-mode speed-up missed");

  chk_speedup_high: assert property (
    lsp_code_above(CMP_W'(meas_s2_q.cm_high), CMP_W'(cmh_thr)) |=> speed_q)
    else $error("positive common-mode speed-up missed");

  chk_power_alarm_three: assert property (
    $stable(param_q[SLOT_PA_ONE + SLOT_W'(2)]) && $stable(meas_s2_q.pair_power[2])
    && lsp_code_above(meas_s2_q.pair_power[2], param_q[SLOT_PA_ONE + SLOT_W'(2)][PA_W-1:0])
    |=> palarm_q[2])
    else $error("power alarm of pair three missed");

  chk_coeff_route: assert property (
    wr_done && hit_param && slot == SLOT_RT_COEFF && pstrb_i[1:0] == 2'h3
    |=> cfg_o.rt_coeff == $past(pwdata_i[COEF_W-1:0]))
    else $error("ring trip coefficient not routed");

  chk_thermal_route: assert property (
    wr_done && hit_param && slot == SLOT_TP_ONE && pstrb_i[1:0] == 2'h3
    |=> cfg_o.thermal_pole[0] == $past(pwdata_i[COEF_W-1:0]))
    else $error("thermal pole of pair one not routed");

  chk_upper_bits_inert: assert property (
    $stable(meas_s2_q) && $stable(lc_upper) && $stable(lc_lower) && $stable(ctrl_q)
    && !loop_closed && !lsp_code_above(CMP_W'(meas_s2_q.loop_current), CMP_W'(lc_upper))
    |=> !loop_closed)
    else $error("loop closure set without current above upper bound");

  chk_ring_trip_set: assert property (
    ring_s2_q && lsp_code_above(CMP_W'(meas_s2_q.loop_current), CMP_W'(rt_thr))
    |=> rtrip_q)
    else $error("ring trip missed while ringing");

  chk_power_alarm_one: assert property (
    lsp_code_above(meas_s2_q.pair_power[0], param_q[SLOT_PA_ONE][PA_W-1:0])
    |=> palarm_q[0])
    else $error("power alarm of pair one missed");

  chk_power_alarm_two: assert property (
    lsp_code_above(meas_s2_q.pair_power[1], param_q[SLOT_PA_ONE + SLOT_W'(1)][PA_W-1:0])
    |=> palarm_q[1])
    else $error("power alarm of pair two missed");

  chk_reserved_read_zero: assert property (
    setup && !pwrite_i && hit_param && slot == SLOT_RESERVED
    |=> prdata_q == '0 && !pslverr_q)
    else $error("reserved slot does not read as zero");

  chk_ctrl_write_store: assert property (
    wr_done && hit_ctrl && pstrb_i[0]
    |=> ctrl_q == $past(pwdata_i[CTRL_W-1:0]))
    else $error("control bits not stored");

  chk_lc_coeff_route: assert property (
    wr_done && hit_param && slot == SLOT_LC_COEFF && pstrb_i[1:0] == 2'h3
    |=> cfg_o.lc_coeff == $past(pwdata_i[COEF_W-1:0]))
    else $error("loop closure coefficient not routed");

  chk_overhead_route: assert property (
    wr_done && hit_param && slot == SLOT_OVERHEAD && pstrb_i[0]
    |=> cfg_o.overhead == $past(pwdata_i[OVH_W-1:0]))
    else $error("overhead voltage field not routed");

endmodule
`default_nettype wire

// ---- sim/lsp_param_bank_tb_top.sv ----
`default_nettype none
module lsp_param_bank_tb_top;
  import lsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  ref_clk_i;
  logic                  resetn_i;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [APB_AW-1:0]     paddr;
  logic [APB_DW-1:0]     pwdata;
  logic [STRB_W-1:0]     pstrb;
  logic [APB_DW-1:0]     prdata_o;
  logic                  pready_o;
  logic                  pslverr_o;
  logic                  ringing;
  lsp_meas_t             meas;
  lsp_det_t              det_o;
  lsp_cfg_t              cfg_o;
  logic [15:0]           p [16];
  int                    fail_count;
  int                    checks;

  lsp_param_bank lsp_param_bank_inst (
    .ref_clk_i        (ref_clk_i),
    .resetn_i         (resetn_i),
    .psel_i           (psel),
    .penable_i        (penable),
    .pwrite_i         (pwrite),
    .paddr_i          (paddr),
    .pwdata_i         (pwdata),
    .pstrb_i          (pstrb),
    .prdata_o         (prdata_o),
    .pready_o         (pready_o),
    .pslverr_o        (pslverr_o),
    .ringing_active_i (ringing),
    .meas_i           (meas),
    .det_o            (det_o),
    .cfg_o            (cfg_o)
  );

  // 25 ns period, 40 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_det(input lsp_det_t got, input lsp_det_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [15:0] wd,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    pstrb   <= s;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, s, r, e);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 16'h0000, 4'h0, r, e);
    cmp_word(r, exp);
    cmp_word({31'h0, e}, {31'h0, experr});
  endtask

  // detection outputs follow inputs after 2 sync stages and 1 compare stage
  task automatic det_step(input logic [5:0] lc, input logic [5:0] cl, input logic [5:0] ch,
                          input logic [23:0] pw, input logic ring, input logic [5:0] exp);
    @(posedge ref_clk_i);
    meas    <= {lc, cl, ch, pw};
    ringing <= ring;
    repeat (4) @(posedge ref_clk_i);
    #1;
    cmp_det(det_o, lsp_det_t'(exp));
  endtask

  // every slot gets a full 16-bit pattern, upper junk bits included
  task automatic s_regs;
    for (int i = 0; i < 16; i++) begin
      p[i] = 16'hf0a5 ^ {4{4'(i)}};
      wr(8'(PARAM_BASE + i), p[i], 4'hf);
    end
    for (int i = 0; i < 16; i++) begin
      rd(8'(PARAM_BASE + i), (i == 14) ? 32'h0000_0000 : {16'h0000, p[i]}, 1'b0);
    end
    cmp_word(32'(cfg_o.lc_coeff), 32'(p[7][12:0]));
    cmp_word(32'(cfg_o.rt_coeff), 32'(p[8][12:0]));
    for (int k = 0; k < 3; k++) begin
      cmp_word(32'(cfg_o.thermal_pole[k]), 32'(p[9+k][12:0]));
    end
  endtask

  // unmapped index, partial strobe, recommended bias and overhead range
  task automatic s_misc;
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(IDX_RING_BIAS, 16'h1234, 4'hf);
    wr(IDX_RING_BIAS, 16'hab06, 4'h1);
    rd(IDX_RING_BIAS, 32'h0000_1206, 1'b0);
    cmp_word(32'(cfg_o.ring_bias), 32'h0000_0006);
    wr(IDX_CTRL, 16'h0002, 4'hf);
    wr(IDX_OVERHEAD, 16'h0009, 4'hf);
    #1; // the write lands at the edge the task returns on
    cmp_word({31'h0, cfg_o.overhead_range_select}, 32'h0000_0001);
    cmp_word(32'(cfg_o.overhead), 32'h0000_0009);
  endtask

  // the loop current, ring trip and low common-mode thresholds carry junk above their fields, which must stay inert
  task automatic s_detect;
    wr(IDX_LC_UPPER, 16'h7f14, 4'hf);
    wr(IDX_LC_LOWER, 16'h400a, 4'hf);
    wr(IDX_RT_THR, 16'h801e, 4'hf);
    wr(IDX_CM_LOW, 16'hc005, 4'hf);
    wr(IDX_CM_HIGH, 16'h0007, 4'hf);
    wr(IDX_PA_ONE, 16'h0064, 4'hf);
    wr(IDX_PA_TWO, 16'h0078, 4'hf);
    wr(IDX_PA_THREE, 16'h008c, 4'hf);
    wr(IDX_CTRL, 16'h0000, 4'hf);
    det_step(6'd21, 6'd0, 6'd0, 24'h0, 1'b0, 6'b100000);
    det_step(6'd20, 6'd0, 6'd0, 24'h0, 1'b0, 6'b000000);
    wr(IDX_CTRL, 16'h0001, 4'hf);
    det_step(6'd21, 6'd0, 6'd0, 24'h0, 1'b0, 6'b100000);
    det_step(6'd10, 6'd0, 6'd0, 24'h0, 1'b0, 6'b100000);
    det_step(6'd9, 6'd0, 6'd0, 24'h0, 1'b0, 6'b000000);
    det_step(6'd15, 6'd0, 6'd0, 24'h0, 1'b0, 6'b000000);
    det_step(6'd31, 6'd0, 6'd0, 24'h0, 1'b0, 6'b100000);
    det_step(6'd31, 6'd0, 6'd0, 24'h0, 1'b1, 6'b110000);
    det_step(6'd30, 6'd0, 6'd0, 24'h0, 1'b1, 6'b100000);
    rd(IDX_STATUS, 32'h0000_0001, 1'b0);
    det_step(6'd0, 6'd6, 6'd0, 24'h0, 1'b0, 6'b001000);
    det_step(6'd0, 6'd5, 6'd7, 24'h0, 1'b0, 6'b000000);
    det_step(6'd0, 6'd0, 6'd8, 24'h0, 1'b0, 6'b001000);
    det_step(6'd0, 6'd0, 6'd0, 24'h000065, 1'b0, 6'b000001);
    det_step(6'd0, 6'd0, 6'd0, 24'h007964, 1'b0, 6'b000010);
    det_step(6'd0, 6'd0, 6'd0, 24'h8d7800, 1'b0, 6'b000100);
    det_step(6'd0, 6'd0, 6'd0, 24'h8c0000, 1'b0, 6'b000000);
  endtask

  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    fail_count++;
    complete_run();
  end

  initial begin
    fail_count = 0;
    checks     = 0;
    resetn_i   = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = '0;
    pstrb      = '0;
    ringing    = 1'b0;
    meas       = '0;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    s_regs();
    s_misc();
    s_detect();
    complete_run();
  end
endmodule
`default_nettype wire
